// File: rtl/dswt_regs.svh
`ifndef DSWT_REGS_SVH
`define DSWT_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DSWT_NTMR           2
`define DSWT_CNT_W          41
`define DSWT_NARROW_W       32
`define DSWT_HI_W           9
`define DSWT_ADDR_W         6
`define DSWT_DATA_W         32
`define DSWT_WIN_W          16

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DSWT_OFF_CMD        6'h00
`define DSWT_OFF_LOAD_LO    6'h04
`define DSWT_OFF_LOAD_HI    6'h08
`define DSWT_OFF_IE         6'h0C
`define DSWT_OFF_CNT0_LO    6'h10
`define DSWT_OFF_CNT0_HI    6'h14
`define DSWT_OFF_CNT1_LO    6'h18
`define DSWT_OFF_CNT1_HI    6'h1C
`define DSWT_OFF_ACTIVE     6'h20
`define DSWT_OFF_FIRED      6'h24
`define DSWT_OFF_CAL_CTRL   6'h28
`define DSWT_OFF_CAL_STAT   6'h2C
`define DSWT_OFF_CAL_RES    6'h30

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define DSWT_CMD_START_BIT   0
`define DSWT_CMD_STOP_BIT   1
`define DSWT_CMD_IESET_BIT  2
`define DSWT_CMD_ID_BIT     4
`define DSWT_CMD_WIDE_BIT   8
`define DSWT_CMD_IEVAL_BIT  12
`define DSWT_CAL_BASIC_BIT  16
`define DSWT_STAT_BUSY_BIT  0
`define DSWT_STAT_DONE_BIT  1
`define DSWT_WAKE_TIMER_ZERO_ID  1'h0
`define DSWT_WAKE_TIMER_ONE_ID   1'h1
`define DSWT_TIMER_ZERO_STATUS_BIT 0
`define DSWT_TIMER_ONE_STATUS_BIT  1

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define DSWT_CAL_BASIC_TICKS 16'h0014
`define DSWT_RST_IE         2'h0
`define DSWT_RST_FIRED      2'h0
`define DSWT_CNT_ONE        41'h000_0000_0001
`define DSWT_CNT_MAX_WIDE   41'h1FF_FFFF_FFFF
`define DSWT_CNT_MAX_NARROW 41'h000_FFFF_FFFF

`endif

// File: rtl/dswt_pkg.sv
`include "dswt_regs.svh"

package dswt_pkg;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_ARM  = 3'b010,
      CAL_RUN  = 3'b100
   } dswt_cal_st_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
   } dswt_sync_st_t;

   typedef struct packed {
      logic [`DSWT_CNT_W-1:0] cnt;
      logic                   active;
      logic                   wide;
      logic                   ie;
      logic                   fire;
      logic                   irq;
   } dswt_cnt_st_t;

   typedef struct packed {
      logic [`DSWT_DATA_W-1:0]                rdata;
      logic [`DSWT_CNT_W-1:0]                 load;
      logic [`DSWT_NTMR-1:0]                  ie_cfg;
      logic [`DSWT_NTMR-1:0]                  fired;
      logic [`DSWT_NTMR-1:0][`DSWT_HI_W-1:0]  hi_snap;
      dswt_cal_st_t                           cal;
      logic [`DSWT_WIN_W-1:0]                 cal_win;
      logic [`DSWT_DATA_W-1:0]                cal_cnt;
      logic [`DSWT_DATA_W-1:0]                cal_res;
      logic                                   cal_done;
      logic                                   wake;
   } dswt_top_st_t;

endpackage

// File: rtl/dswt_tmr_if.sv
`include "dswt_regs.svh"

interface dswt_tmr_if;
   logic                   start;
   logic                   stop;
   logic [`DSWT_CNT_W-1:0] load;
   logic                   wide;
   logic                   ie;
   logic                   tick;
   logic [`DSWT_CNT_W-1:0] count;
   logic                   active;
   logic                   fire;
   logic                   irq;

   modport ctl (
      output start, stop, load, wide, ie, tick,
      input  count, active, fire, irq
   );
   modport tmr (
      input  start, stop, load, wide, ie, tick,
      output count, active, fire, irq
   );
endinterface

// File: rtl/dswt_sync.sv
module dswt_sync (
   input  wire logic i_ref_clk,
   input  wire logic i_arst_n,
   input  wire logic i_pin,
   output logic      o_rise
);

   dswt_pkg::dswt_sync_st_t q;
   dswt_pkg::dswt_sync_st_t d;

   // ----------------------------------------------------------------
   // three stage sampler, level accepted when stages two and three agree
   // ----------------------------------------------------------------
   always_comb begin
      d      = q;
      d.s1   = i_pin;
      d.s2   = q.s1;
      d.s3   = q.s2;
      d.rise = 1'b0;
      if (q.s2 == q.s3) begin
         d.lvl  = q.s3;
         d.rise = q.s3 & ~q.lvl;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_rise = q.rise;

endmodule

// File: rtl/dswt_cnt.sv
`include "dswt_regs.svh"

module dswt_cnt (
   input  wire logic i_ref_clk,
   input  wire logic i_arst_n,
   dswt_tmr_if.tmr   io_tmr
);

   dswt_pkg::dswt_cnt_st_t q;
   dswt_pkg::dswt_cnt_st_t d;

   // ----------------------------------------------------------------
   // down-counter with wrap
   // ----------------------------------------------------------------
   always_comb begin
      d      = q;
      d.fire = 1'b0;
      d.irq  = 1'b0;
      if (io_tmr.start) begin
         d.active = 1'b1;
         d.wide   = io_tmr.wide;
         d.ie     = io_tmr.ie;
         d.cnt    = io_tmr.wide ? io_tmr.load
                    : {9'h000, io_tmr.load[`DSWT_NARROW_W-1:0]};
      end else if (io_tmr.stop) begin
         d.active = 1'b0;
      end else if (q.active && io_tmr.tick) begin
         if (q.cnt == `DSWT_CNT_ONE) begin
            d.fire = 1'b1;
            d.irq  = q.ie;
            d.cnt  = q.wide ? `DSWT_CNT_MAX_WIDE
                     : `DSWT_CNT_MAX_NARROW;
         end else begin
            d.cnt = q.wide ? q.cnt - `DSWT_CNT_ONE
                    : {9'h000, q.cnt[`DSWT_NARROW_W-1:0] - 32'h0000_0001};
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign io_tmr.count  = q.cnt;
   assign io_tmr.active = q.active;
   assign io_tmr.fire   = q.fire;
   assign io_tmr.irq    = q.irq;

endmodule

// File: rtl/dswt_top.sv
// What this block does
// - two wake timers, chosen by identifier
// - each counter is 41 bits wide
// - start loads value, decrements per slow tick
// - value counts slow clock periods
// - at zero: fire, wrap to all ones, continue
// - wide start enables upper nine bits
// - reading count leaves counter undisturbed
// - stop halts count, raises no interrupt
// - interrupt enable set before start; stop keeps it
// - enabled expiry wakes device, disabled does not
// - active bitmap, one bit per timer
// - active stays set across wrap until stop
// - fired bitmap set on zero, cleared on read
// - basic calibration: timer 0, twenty slow ticks
// - basic result 10000 at nominal slow clock
// - enhanced calibration over chosen tick window
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "dswt_regs.svh"

module dswt_top (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_arst_n,
   input  wire logic                    i_slow_clk,
   input  wire logic                    i_per_clk,
   input  wire logic [`DSWT_ADDR_W-1:0] i_addr,
   input  wire logic [`DSWT_DATA_W-1:0] i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic      [`DSWT_DATA_W-1:0] o_rdata,
   output logic                         o_wake
);

   dswt_pkg::dswt_top_st_t q;
   dswt_pkg::dswt_top_st_t d;

   logic                                 slow_tick;
   logic                                 per_tick;
   logic [`DSWT_NTMR-1:0]                start_v;
   logic [`DSWT_NTMR-1:0]                stop_v;
   logic [`DSWT_NTMR-1:0]                wide_v;
   logic [`DSWT_NTMR-1:0]                ie_v;
   logic [`DSWT_NTMR-1:0][`DSWT_CNT_W-1:0] load_v;
   logic [`DSWT_NTMR-1:0][`DSWT_CNT_W-1:0] cnt_v;
   logic [`DSWT_NTMR-1:0]                active_v;
   logic [`DSWT_NTMR-1:0]                fire_v;
   logic [`DSWT_NTMR-1:0]                irq_v;
   logic [`DSWT_NTMR-1:0]                cal_mask;
   logic                                 cmd_id;
   logic                                 cmd_blocked;
   logic                                 cmd_wr;

   // ----------------------------------------------------------------
   // pin samplers
   // ----------------------------------------------------------------
   dswt_sync u_slow_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (i_slow_clk),
      .o_rise    (slow_tick)
   );

   dswt_sync u_per_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (i_per_clk),
      .o_rise    (per_tick)
   );

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `DSWT_NTMR; g = g + 1) begin : g_tmr
         dswt_tmr_if u_if ();
         assign u_if.start  = start_v[g];
         assign u_if.stop   = stop_v[g];
         assign u_if.load   = load_v[g];
         assign u_if.wide   = wide_v[g];
         assign u_if.ie     = ie_v[g];
         assign u_if.tick   = slow_tick;
         assign cnt_v[g]    = u_if.count;
         assign active_v[g] = u_if.active;
         assign fire_v[g]   = u_if.fire;
         assign irq_v[g]    = u_if.irq;
         dswt_cnt u_cnt (
            .i_ref_clk (i_ref_clk),
            .i_arst_n  (i_arst_n),
            .io_tmr    (u_if.tmr)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   always_comb begin
      cmd_wr      = i_wr && (i_addr == `DSWT_OFF_CMD);
      cmd_id      = i_wdata[`DSWT_CMD_ID_BIT];
      cmd_blocked = (cmd_id == `DSWT_WAKE_TIMER_ZERO_ID)
                    && (q.cal != dswt_pkg::CAL_IDLE);
      cal_mask    = '0;
      cal_mask[`DSWT_TIMER_ZERO_STATUS_BIT] = (q.cal != dswt_pkg::CAL_IDLE);
      for (int i = 0; i < `DSWT_NTMR; i++) begin
         start_v[i] = cmd_wr && !cmd_blocked && (cmd_id == i[0])
                      && i_wdata[`DSWT_CMD_START_BIT];
         stop_v[i]  = cmd_wr && !cmd_blocked && (cmd_id == i[0])
                      && (i_wdata[`DSWT_CMD_STOP_BIT]
                          || i_wdata[`DSWT_CMD_IESET_BIT]);
         wide_v[i]  = i_wdata[`DSWT_CMD_WIDE_BIT];
         ie_v[i]    = q.ie_cfg[i];
         load_v[i]  = q.load;
      end
      // calibration owns timer 0 and starts it on a slow edge
      if (q.cal == dswt_pkg::CAL_ARM) begin
         start_v[0] = slow_tick;
         stop_v[0]  = 1'b0;
         wide_v[0]  = 1'b0;
         ie_v[0]    = 1'b0;
         load_v[0]  = {25'h000_0000, q.cal_win};
      end
      if (q.cal == dswt_pkg::CAL_RUN) begin
         start_v[0] = 1'b0;
         stop_v[0]  = fire_v[0];
      end
   end

   // ----------------------------------------------------------------
   // state update
   // ----------------------------------------------------------------
   always_comb begin
      d       = q;
      d.rdata = '0;
      d.wake  = |(irq_v & ~cal_mask);

      // fired bitmap: a set in the read cycle wins
      if (i_rd && (i_addr == `DSWT_OFF_FIRED)) begin
         d.fired = '0;
      end
      d.fired = d.fired | (fire_v & ~cal_mask);

      if (i_wr) begin
         unique case (i_addr)
            `DSWT_OFF_LOAD_LO: begin
               d.load[`DSWT_NARROW_W-1:0] = i_wdata;
            end
            `DSWT_OFF_LOAD_HI: begin
               d.load[`DSWT_CNT_W-1:`DSWT_NARROW_W] =
                  i_wdata[`DSWT_HI_W-1:0];
            end
            `DSWT_OFF_CMD: begin
               if (!cmd_blocked && i_wdata[`DSWT_CMD_IESET_BIT]) begin
                  d.ie_cfg[cmd_id] = i_wdata[`DSWT_CMD_IEVAL_BIT];
               end
            end
            `DSWT_OFF_CAL_CTRL: begin
               d.cal      = dswt_pkg::CAL_ARM;
               d.cal_cnt  = '0;
               d.cal_done = 1'b0;
               d.cal_win  = i_wdata[`DSWT_CAL_BASIC_BIT]
                            ? `DSWT_CAL_BASIC_TICKS
                            : i_wdata[`DSWT_WIN_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // calibration sequence
      unique case (q.cal)
         dswt_pkg::CAL_IDLE: begin
         end
         dswt_pkg::CAL_ARM: begin
            if (slow_tick) begin
               d.cal = dswt_pkg::CAL_RUN;
            end
         end
         dswt_pkg::CAL_RUN: begin
            if (per_tick) begin
               d.cal_cnt = q.cal_cnt + 32'h0000_0001;
            end
            if (fire_v[0]) begin
               d.cal      = dswt_pkg::CAL_IDLE;
               d.cal_done = 1'b1;
               d.cal_res  = per_tick ? q.cal_cnt + 32'h0000_0001
                            : q.cal_cnt;
            end
         end
      endcase

      // register reads, answer in the next cycle
      if (i_rd) begin
         unique case (i_addr)
            `DSWT_OFF_LOAD_LO: d.rdata = q.load[`DSWT_NARROW_W-1:0];
            `DSWT_OFF_LOAD_HI: d.rdata = {23'h00_0000,
                                   q.load[`DSWT_CNT_W-1:`DSWT_NARROW_W]};
            `DSWT_OFF_IE:      d.rdata = {30'h0000_0000, q.ie_cfg};
            `DSWT_OFF_CNT0_LO: begin
               d.rdata      = cnt_v[0][`DSWT_NARROW_W-1:0];
               d.hi_snap[0] = cnt_v[0][`DSWT_CNT_W-1:`DSWT_NARROW_W];
            end
            `DSWT_OFF_CNT0_HI: d.rdata = {23'h00_0000, q.hi_snap[0]};
            `DSWT_OFF_CNT1_LO: begin
               d.rdata      = cnt_v[1][`DSWT_NARROW_W-1:0];
               d.hi_snap[1] = cnt_v[1][`DSWT_CNT_W-1:`DSWT_NARROW_W];
            end
            `DSWT_OFF_CNT1_HI: d.rdata = {23'h00_0000, q.hi_snap[1]};
            `DSWT_OFF_ACTIVE:  d.rdata = {30'h0000_0000, active_v};
            `DSWT_OFF_FIRED:   d.rdata = {30'h0000_0000, q.fired};
            `DSWT_OFF_CAL_STAT: begin
               d.rdata = '0;
               d.rdata[`DSWT_STAT_BUSY_BIT] = (q.cal != dswt_pkg::CAL_IDLE);
               d.rdata[`DSWT_STAT_DONE_BIT] = q.cal_done;
            end
            `DSWT_OFF_CAL_RES: d.rdata = q.cal_res;
            default:           d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q        <= '0;
         q.cal    <= dswt_pkg::CAL_IDLE;
         q.ie_cfg <= `DSWT_RST_IE;
         q.fired  <= `DSWT_RST_FIRED;
      end else begin
         q <= d;
      end
   end

   assign o_rdata = q.rdata;
   assign o_wake  = q.wake;

endmodule

// File: testbench/dswt_top_assertions.sv
`include "dswt_regs.svh"

module dswt_top_chk (
   input wire logic                    i_ref_clk,
   input wire logic                    i_arst_n,
   input wire logic                    i_slow_clk,
   input wire logic                    i_per_clk,
   input wire logic [`DSWT_ADDR_W-1:0] i_addr,
   input wire logic [`DSWT_DATA_W-1:0] i_wdata,
   input wire logic                    i_wr,
   input wire logic                    i_rd,
   input wire logic [`DSWT_DATA_W-1:0] o_rdata,
   input wire logic                    o_wake
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------
   // bus and wake properties
   // ----------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   chk_rdata_idle: assert property (
      !i_rd |=> o_rdata == '0) else $error("data outside read slot");
   chk_cmd_reads_zero: assert property (
      i_rd && i_addr == `DSWT_OFF_CMD |=> o_rdata == '0)
      else $error("command register not zero");
   chk_unmapped_zero: assert property (
      i_rd && i_addr >= 6'h34 |=> o_rdata == '0)
      else $error("unmapped read not zero");
   chk_ie_width: assert property (
      i_rd && i_addr == `DSWT_OFF_IE |=> o_rdata[31:2] == '0)
      else $error("enable read too wide");
   chk_bitmap_width: assert property (
      i_rd && (i_addr == `DSWT_OFF_ACTIVE || i_addr == `DSWT_OFF_FIRED)
      |=> o_rdata[31:2] == '0) else $error("bitmap too wide");
   chk_cnt_hi_width: assert property (
      i_rd && (i_addr == `DSWT_OFF_CNT0_HI || i_addr == `DSWT_OFF_CNT1_HI)
      |=> o_rdata[31:9] == '0) else $error("count high too wide");
   chk_cal_stat_width: assert property (
      i_rd && i_addr == `DSWT_OFF_CAL_STAT |=> o_rdata[31:2] == '0)
      else $error("cal status too wide");
   chk_wake_pulse: assert property (
      o_wake |=> !o_wake) else $error("wake longer than one cycle");
   chk_wake_quiet_rst: assert property (
      $rose(i_arst_n) |-> !o_wake ##1 !o_wake)
      else $error("wake right after reset");

   cover property (o_wake);
   cover property (i_rd && i_addr == `DSWT_OFF_FIRED ##1 o_rdata[1:0] != 0);
   cover property (i_rd && i_addr == `DSWT_OFF_CAL_RES ##1 o_rdata != 0);
endmodule

bind dswt_top dswt_top_chk i_dswt_top_chk (
   .i_ref_clk  (i_ref_clk),
   .i_arst_n   (i_arst_n),
   .i_slow_clk (i_slow_clk),
   .i_per_clk  (i_per_clk),
   .i_addr     (i_addr),
   .i_wdata    (i_wdata),
   .i_wr       (i_wr),
   .i_rd       (i_rd),
   .o_rdata    (o_rdata),
   .o_wake     (o_wake)
);

// File: testbench/dswt_top_tb.sv
`include "dswt_regs.svh"

module dswt_top_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SLOW_P = 806;
   localparam int PER_P  = 82;

   logic        i_ref_clk;
   logic        i_arst_n;
   logic        i_slow_clk;
   logic        i_per_clk;
   logic [5:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic        o_wake;
   int          error_cnt;
   int          n_compared;
   int          wake_n;

   dswt_top i_dswt_top (
      .i_ref_clk  (i_ref_clk),
      .i_arst_n   (i_arst_n),
      .i_slow_clk (i_slow_clk),
      .i_per_clk  (i_per_clk),
      .i_addr     (i_addr),
      .i_wdata    (i_wdata),
      .i_wr       (i_wr),
      .i_rd       (i_rd),
      .o_rdata    (o_rdata),
      .o_wake     (o_wake)
   );

   // ----------
   // clocks and monitors
   // ----------
   always #10 i_ref_clk = ~i_ref_clk;
   always #(SLOW_P/2) i_slow_clk = ~i_slow_clk;
   always #(PER_P/2) i_per_clk = ~i_per_clk;
   always @(posedge i_ref_clk) begin
      if (o_wake === 1'b1) wake_n++;
   end

   // ----------
   // helpers
   // ----------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge i_ref_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
      @(negedge i_ref_clk);
      d = o_rdata;
   endtask

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------
   // scenarios
   // ----------
   task automatic t_reset;
      logic [5:0]  adr [10] = '{6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C,
                                6'h20, 6'h24, 6'h2C, 6'h30, 6'h3C};
      logic [31:0] d;
      wr(6'h3C, 32'hFFFF_FFFF);
      foreach (adr[k]) begin
         rd(adr[k], d);
         chk(d, 32'h0, "reset or unmapped value");
      end
      $display("test reset done");
   endtask

   task automatic t_fire;
      logic [31:0] a;
      int          k;
      wr(6'h00, 32'h0000_1004);
      wr(6'h04, 32'h0000_0003);
      wr(6'h08, 32'h0000_0000);
      @(negedge i_slow_clk);
      wr(6'h00, 32'h0000_0101);
      rd(6'h10, a);
      chk(a, 32'h3, "loaded count");
      @(negedge i_slow_clk);
      rd(6'h10, a);
      chk(a, 32'h2, "count after one tick");
      k = 0;
      while (wake_n < 1 && k < 4000) begin
         @(negedge i_ref_clk);
         k++;
      end
      chk(32'(wake_n), 32'h1, "wake on fire");
      rd(6'h24, a);
      chk(a, 32'h1, "fired bitmap");
      rd(6'h24, a);
      chk(a, 32'h0, "fired cleared by read");
      rd(6'h10, a);
      chk(a, 32'hFFFF_FFFF, "wrapped low");
      rd(6'h14, a);
      chk(a, 32'h0000_01FF, "wrapped high wide");
      rd(6'h20, a);
      chk(a, 32'h1, "active after wrap");
      $display("test fire done");
   endtask

   task automatic t_narrow;
      logic [31:0] a;
      wr(6'h00, 32'h0000_0014);
      wr(6'h04, 32'h0000_0002);
      wr(6'h00, 32'h0000_0011);
      rd(6'h20, a);
      chk(a, 32'h3, "both active");
      repeat (3) @(negedge i_slow_clk);
      rd(6'h24, a);
      chk(a, 32'h2, "timer one fired");
      chk(32'(wake_n), 32'h1, "no wake when disabled");
      rd(6'h18, a);
      rd(6'h1C, a);
      chk(a, 32'h0, "narrow wrap high");
      rd(6'h20, a);
      chk(a, 32'h3, "still active");
      $display("test narrow done");
   endtask

   task automatic t_stop;
      logic [31:0] a;
      logic [31:0] b;
      wr(6'h00, 32'h0000_0002);
      rd(6'h20, a);
      chk(a, 32'h2, "timer zero inactive");
      rd(6'h0C, a);
      chk(a, 32'h1, "enable kept on stop");
      @(negedge i_slow_clk);
      rd(6'h10, a);
      @(negedge i_slow_clk);
      rd(6'h10, b);
      chk(b, a, "count frozen");
      chk(32'(wake_n), 32'h1, "no wake on stop");
      $display("test stop done");
   endtask

   task automatic t_cal(input logic [31:0] ctl, input int w);
      logic [31:0] a;
      int          k;
      int          e;
      e = w * SLOW_P / PER_P;
      wr(6'h28, ctl);
      a = '0;
      k = 0;
      while (a[1] !== 1'b1 && k < 2000) begin
         rd(6'h2C, a);
         k++;
      end
      chk({31'h0, a[1]}, 32'h1, "calibration done");
      rd(6'h30, a);
      n_compared++;
      if ((a + 3 >= e && a <= e + 3) !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t cal result %0d near %0d", $time, a, e);
      end
      rd(6'h24, a);
      chk(a, 32'h0, "no fired bit from cal");
      chk(32'(wake_n), 32'h1, "no wake from cal");
      $display("test calibration done");
   endtask

   // ----------
   // main sequence
   // ----------
   initial begin
      i_ref_clk  = 1'b0;
      i_slow_clk = 1'b0;
      i_per_clk  = 1'b0;
      i_arst_n   = 1'b0;
      i_addr     = 6'h00;
      i_wdata    = 32'h0;
      i_wr       = 1'b0;
      i_rd       = 1'b0;
      error_cnt  = 0;
      n_compared = 0;
      wake_n     = 0;
      repeat (2) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      t_reset;
      t_fire;
      t_narrow;
      t_stop;
      t_cal(32'h0001_0000, 20);
      t_cal(32'h0000_0007, 7);
      summarize;
   end

   initial begin
      repeat (30000) @(posedge i_ref_clk);
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      summarize;
   end
endmodule
